// ### rtl/tfba_map.vh
// Constants for the transmit frame buffer arbiter.
// Assumes inclusion by the arbiter modules only.
`ifndef TFBA_MAP_VH
`define TFBA_MAP_VH
// Word addresses inside a transmit_frame_buffer memory
`define TFBA_ADDR_FFW 5'h00
`define TFBA_ADDR_IDW 5'h01
`define TFBA_ADDR_TSL 5'h02
`define TFBA_ADDR_TSU 5'h03
`define TFBA_ADDR_W 5
// Arbiter states
`define TFBA_ST_IDLE 3'h0
`define TFBA_ST_TSL 3'h1
`define TFBA_ST_TSU 3'h2
`define TFBA_ST_FFW 3'h3
`define TFBA_ST_IDW 3'h4
`define TFBA_ST_VALID 3'h5
`define TFBA_ST_LOCK 3'h6
// Reset values
`define TFBA_RST_IDX 3'h0
`define TFBA_RST_WORD 32'h0000_0000
`endif

// ### rtl/tfba_prio_sel.v
// Priority selector for the transmit frame buffers.
// Assumes priorities packed 3 bits per buffer, buffer 0 in the low bits.
`timescale 1ns/10ps
module tfba_prio_sel #(
    parameter NBUF = 8,
    parameter PW = 3,
    parameter IW = 3
) (
    input wire [NBUF-1:0] avail,
    input wire [NBUF*PW-1:0] prio,
    output reg any,
    output reg [IW-1:0] sel
);
    integer i;
    reg [PW-1:0] best;
    // Greatest priority wins; ties keep the lowest index
    always @*
    begin
        any = 1'b0;
        sel = {IW{1'b0}};
        best = {PW{1'b0}};
        for (i = 0; i < NBUF; i = i + 1)
        begin
            if (avail[i] && (!any || prio[i*PW +: PW] > best))
            begin
                any = 1'b1;
                best = prio[i*PW +: PW];
                sel = i[IW-1:0];
            end
        end
    end
endmodule

// ### rtl/tfba_parity.v
// Even parity check of one memory word.
// Assumes the stored parity bit makes the total count of ones even.
`timescale 1ns/10ps
module tfba_parity #(
    parameter DW = 32
) (
    input wire [DW-1:0] word,
    input wire par,
    output wire err
);
    // Odd total count is an error
    assign err = ^{word, par};
endmodule

// ### rtl/tfba_arbiter.v
// Transmit frame buffer arbiter: selects, validates and hands a frame
// to protocol control. Assumes memory read data arrives one clock after
// the address, and lock/unlock come as one-cycle pulses.
//
// Notes on behaviour
// - Wait while time is below frame timestamp; low word kept in a register.
// - Continue validation once time reaches or passes the timestamp.
// - Read the format word into hidden double-buffer registers.
// - Load identifier and copy double-buffer to outputs in one cycle.
// - After both captures, buffer is validated and frame-available rises.
// - Lock marks buffer used, starts its transmission, arbiter goes locked.
// - While locked no validation runs; new buffers are ignored.
// - Unlock-done ends use; with no other buffer report none validated.
// - Greater configured priority wins among available buffers.
// - A new selected buffer restarts validation on that buffer.
// - Previous buffer stays validated while the new one is checked.
// - Validated index switches only when the new validation finishes.
// - Abort of validated buffer drops frame-available at once, to idle.
// - Parity error in validation words stops it and is reported.
//
// Validation walk, one state per clock:
//   IDLE  - nothing under check; leaves as soon as a buffer is selected
//   TSL   - low timestamp word on the read port, copied to ts_low
//   TSU   - high word on the read port; waits here while time is early
//   FFW   - format word on the read port, kept in the hidden copy
//   IDW   - identifier on the read port; index, identifier and format
//           move to the outputs together on the closing edge
//   VALID - frame offered; a new selection restarts at TSL
//   LOCK  - transmission running, selection ignored until unlock
//
// Read addresses come from the next state, so each word is on the read
// port exactly while its state is current.
//
// Hazards kept in mind:
//   - frame_valid is combinational so an abort hides the frame in the
//     very cycle the buffer drops; a lock in that cycle is refused.
//   - the previous validated buffer stays offered during a restart, so
//     protocol control never sees a gap between two ready buffers.
//   - a lock and a restart in one cycle: the lock wins and the
//     restart is forgotten; validation resumes after unlock.
//   - a parity fault ends the check and reports the candidate buffer;
//     the previously validated frame stays offered.
`timescale 1ns/10ps
`include "tfba_map.vh"
module tfba_arbiter #(
    parameter NBUF = 8,
    parameter PW = 3,
    parameter IW = 3,
    parameter DW = 32
) (
    input wire clk,
    input wire rst_n,
    input wire [NBUF-1:0] buf_avail,
    input wire [NBUF*PW-1:0] buf_prio,
    input wire [2*DW-1:0] time_now,
    output reg [`TFBA_ADDR_W-1:0] mem_addr,
    output reg [IW-1:0] mem_idx,
    input wire [DW-1:0] mem_data,
    input wire mem_par,
    input wire lock_cmd,
    input wire unlock_cmd,
    output wire frame_valid,
    output reg [IW-1:0] valid_idx,
    output reg [DW-1:0] frame_meta,
    output reg [DW-1:0] frame_ident,
    output reg used_pulse,
    output reg done_pulse,
    output reg parity_err,
    output reg [IW-1:0] parity_idx,
    output reg locked
);
    ////////////////////////////////////////////////////////////////////
    // Selection and parity
    wire any_avail;
    wire [IW-1:0] sel_idx;
    wire word_err;
    tfba_prio_sel #(
        .NBUF(NBUF),
        .PW(PW),
        .IW(IW)
    ) u_sel (
        .avail(buf_avail),
        .prio(buf_prio),
        .any(any_avail),
        .sel(sel_idx)
    );
    tfba_parity #(
        .DW(DW)
    ) u_par (
        .word(mem_data),
        .par(mem_par),
        .err(word_err)
    );

    ////////////////////////////////////////////////////////////////////
    // State
    reg [2:0] state;
    reg [2:0] next_state;
    reg [IW-1:0] cand_idx;
    reg [DW-1:0] ts_low;
    reg [DW-1:0] meta_dbuf;
    reg has_valid;
    wire [2*DW-1:0] frame_ts;
    wire validating;
    wire restart;
    wire valid_gone;
    wire par_fault;

    assign frame_ts = {mem_data, ts_low};
    assign validating = (state == `TFBA_ST_TSL) || (state == `TFBA_ST_TSU) ||
        (state == `TFBA_ST_FFW) || (state == `TFBA_ST_IDW);
    // Selection moved away from the buffer under check
    assign restart = any_avail && (sel_idx != cand_idx) &&
        (validating || state == `TFBA_ST_VALID);
    // Validated buffer lost without a lock in progress
    assign valid_gone = has_valid && !locked && !buf_avail[valid_idx];
    // Drops in the same cycle as the abort
    assign frame_valid = has_valid && !locked && buf_avail[valid_idx];
    // Bad parity on any word under check, both timestamp halves included
    assign par_fault = validating && word_err;

    // Next state
    always @*
    begin
        next_state = state;
        case (state)
            `TFBA_ST_IDLE:
                if (any_avail)
                    next_state = `TFBA_ST_TSL;
            `TFBA_ST_TSL:
                next_state = `TFBA_ST_TSU;
            `TFBA_ST_TSU:
                if (time_now >= frame_ts)
                    next_state = `TFBA_ST_FFW;
            `TFBA_ST_FFW:
                next_state = `TFBA_ST_IDW;
            `TFBA_ST_IDW:
                next_state = `TFBA_ST_VALID;
            `TFBA_ST_VALID:
                next_state = `TFBA_ST_VALID;
            `TFBA_ST_LOCK:
                if (unlock_cmd)
                    next_state = `TFBA_ST_IDLE;
            default:
                next_state = `TFBA_ST_IDLE;
        endcase
        if (state != `TFBA_ST_LOCK)
        begin
            if (frame_valid && lock_cmd)
                next_state = `TFBA_ST_LOCK;
            else if (valid_gone)
                next_state = `TFBA_ST_IDLE;
            else if (par_fault)
                next_state = `TFBA_ST_IDLE;
            else if (!any_avail && state != `TFBA_ST_IDLE)
                next_state = `TFBA_ST_IDLE;
            else if (restart)
                next_state = `TFBA_ST_TSL;
        end
    end

    // Buffer word read while the given state is current
    function [`TFBA_ADDR_W-1:0] word_addr;
        input [2:0] st;
    begin
        if (st == `TFBA_ST_TSU)
            word_addr = `TFBA_ADDR_TSU;
        else if (st == `TFBA_ST_FFW)
            word_addr = `TFBA_ADDR_FFW;
        else if (st == `TFBA_ST_IDW)
            word_addr = `TFBA_ADDR_IDW;
        else
            word_addr = `TFBA_ADDR_TSL;
    end
    endfunction

    // Memory address for the word read in the following state
    always @*
    begin
        mem_idx = cand_idx;
        mem_addr = word_addr(next_state);
        if (next_state == `TFBA_ST_TSL)
            mem_idx = sel_idx;
        if (locked)
            mem_idx = valid_idx;
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    // Sequencer state and the candidate under check
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= `TFBA_ST_IDLE;
            cand_idx <= `TFBA_RST_IDX;
        end
        else
        begin
            state <= next_state;
            // Candidate frozen from the first word to the swap
            if (next_state == `TFBA_ST_TSL && state != `TFBA_ST_LOCK)
                cand_idx <= sel_idx;
        end
    end

    // Hidden word copies, never seen by protocol control
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ts_low <= `TFBA_RST_WORD;
            meta_dbuf <= `TFBA_RST_WORD;
        end
        else
        begin
            // Lower timestamp word held while upper is compared
            if (state == `TFBA_ST_TSL)
                ts_low <= mem_data;
            // Format word parked until the identifier arrives
            if (state == `TFBA_ST_FFW && next_state == `TFBA_ST_IDW)
                meta_dbuf <= mem_data;
        end
    end

    // Offered frame: index, identifier and format swap in one edge
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid_idx <= `TFBA_RST_IDX;
            has_valid <= 1'b0;
            frame_meta <= `TFBA_RST_WORD;
            frame_ident <= `TFBA_RST_WORD;
        end
        else
        begin
            if (state == `TFBA_ST_IDW && next_state == `TFBA_ST_VALID)
            begin
                frame_ident <= mem_data;
                frame_meta <= meta_dbuf;
                valid_idx <= cand_idx;
                has_valid <= 1'b1;
            end
            // Aborted frame forgotten; the lock path keeps it
            if (valid_gone && next_state != `TFBA_ST_LOCK)
                has_valid <= 1'b0;
            // Sent frame forgotten, nothing offered until revalidated
            if (state == `TFBA_ST_LOCK && unlock_cmd)
                has_valid <= 1'b0;
        end
    end

    // Lock flag and one-cycle reports to the buffers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            locked <= 1'b0;
            used_pulse <= 1'b0;
            done_pulse <= 1'b0;
            parity_err <= 1'b0;
            parity_idx <= `TFBA_RST_IDX;
        end
        else
        begin
            used_pulse <= 1'b0;
            done_pulse <= 1'b0;
            parity_err <= 1'b0;
            // Fault ends this check; blame the candidate buffer
            if (par_fault && next_state == `TFBA_ST_IDLE && !valid_gone)
            begin
                parity_err <= 1'b1;
                parity_idx <= cand_idx;
            end
            // Lock taken: buffer used, its transmission starts
            if (state != `TFBA_ST_LOCK && next_state == `TFBA_ST_LOCK)
            begin
                locked <= 1'b1;
                used_pulse <= 1'b1;
            end
            // Unlock-done: buffer reports success, arbiter free again
            if (state == `TFBA_ST_LOCK && unlock_cmd)
            begin
                locked <= 1'b0;
                done_pulse <= 1'b1;
            end
        end
    end
endmodule

// ### tb/tfba_arbiter_monitor.sv
// Port checker for the transmit frame buffer arbiter.
// Assumes binding to tfba_arbiter, port names unchanged.
`timescale 1ns/10ps
module tfba_arbiter_monitor #(
    parameter NBUF = 8,
    parameter IW = 3,
    parameter DW = 32
) (
    input wire clk,
    input wire rst_n,
    input wire [NBUF-1:0] buf_avail,
    input wire lock_cmd,
    input wire unlock_cmd,
    input wire frame_valid,
    input wire [IW-1:0] valid_idx,
    input wire [DW-1:0] frame_ident,
    input wire [DW-1:0] mem_data,
    input wire used_pulse,
    input wire done_pulse,
    input wire locked
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // Lock and unlock handshake
    lock_take_a: assert property (
        lock_cmd && frame_valid |=> locked && used_pulse)
        else $error("lock not taken");
    used_cause_a: assert property (
        used_pulse |-> $past(lock_cmd && frame_valid))
        else $error("stray used pulse");
    lock_quiet_a: assert property (
        locked |-> !frame_valid)
        else $error("frame offered while locked");
    lock_frozen_a: assert property (
        locked && $past(locked) |-> $stable(valid_idx) &&
        $stable(frame_ident))
        else $error("locked frame changed");
    lock_hold_a: assert property (
        locked && !unlock_cmd |=> locked)
        else $error("lock lost");
    unlock_done_a: assert property (
        locked && unlock_cmd |=> !locked && done_pulse)
        else $error("unlock not taken");
    done_cause_a: assert property (
        done_pulse |-> !locked && $past(locked))
        else $error("stray done pulse");
    // Offer and captured identifier
    abort_drop_a: assert property (
        frame_valid |-> buf_avail[valid_idx])
        else $error("offer of unavailable buffer");
    ident_load_a: assert property (
        $rose(frame_valid) |-> frame_ident == $past(mem_data))
        else $error("identifier not captured");
    reset_idle_a: assert property (
        disable iff (1'b0) !rst_n |-> !frame_valid && !locked)
        else $error("not idle in reset");
    cover property (lock_cmd && frame_valid);
    cover property (unlock_cmd && locked);
    cover property ($fell(frame_valid) && !locked);
endmodule
bind tfba_arbiter tfba_arbiter_monitor #(.NBUF(NBUF), .IW(IW), .DW(DW))
    u_mon (.*);

// ### tb/tfba_mem_model.sv
// Buffer memory model: answers one clock after the address.
// Assumes words 0/1 format and identifier, 2/3 the timestamp.
`timescale 1ns/10ps
module tfba_mem_model (
    input wire clk,
    input wire [4:0] addr,
    input wire [2:0] idx,
    input wire [63:0] ts,
    input wire bad_par,
    output reg [31:0] data,
    output reg par
);
    wire [31:0] w = addr[1] ? (addr[0] ? ts[63:32] : ts[31:0])
                            : {idx, addr, 24'h5a5a5a};
    // Registered read with even parity, broken on request
    always @(posedge clk)
    begin
        data <= w;
        par <= (^w) ^ bad_par;
    end
endmodule

// ### tb/tb_tfba_arbiter.sv
// Self-checking bench for the transmit frame buffer arbiter.
// Assumes the memory model and the bound port checker.
`timescale 1ns/10ps
module tb_tfba_arbiter;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] avail = 8'h00;
    reg [23:0] prio = 24'h038688;
    reg [63:0] tnow = 64'h0;
    reg [63:0] ts = 64'h0000_0001_0000_0000;
    reg lock = 1'b0;
    reg unlock = 1'b0;
    reg bad = 1'b0;
    wire [4:0] addr;
    wire [2:0] idx, vidx, pidx;
    wire [31:0] md, meta, ident;
    wire mp, fv, used, done, perr, lkd;
    integer error_cnt = 0;
    integer n_checks = 0;
    tfba_arbiter u_dut (.clk(clk), .rst_n(rst_n), .buf_avail(avail),
        .buf_prio(prio), .time_now(tnow), .mem_addr(addr), .mem_idx(idx),
        .mem_data(md), .mem_par(mp), .lock_cmd(lock), .unlock_cmd(unlock),
        .frame_valid(fv), .valid_idx(vidx), .frame_meta(meta),
        .frame_ident(ident), .used_pulse(used), .done_pulse(done),
        .parity_err(perr), .parity_idx(pidx), .locked(lkd));
    tfba_mem_model u_mem (.clk(clk), .addr(addr), .idx(idx), .ts(ts),
        .bad_par(bad), .data(md), .par(mp));
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////
    function [31:0] wd(input [2:0] i, input [4:0] a);
        wd = {i, a, 24'h5a5a5a};
    endfunction
    task chk(input [31:0] got, input [31:0] exp, input [63:0] nm);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0s exp %h got %h", nm, exp, got);
        end
    end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task wait_fv;
        integer i;
        for (i = 0; i < 20 && fv !== 1'b1; i = i + 1)
            cyc(1);
    endtask
    // One-cycle lock or unlock pulse from protocol control
    task cmd(input u);
    begin
        lock = !u;
        unlock = u;
        cyc(1);
        lock = 1'b0;
        unlock = 1'b0;
    end
    endtask
    // Single buffer: time gate, captures, lock, unlock
    task t_basic;
    begin
        avail = 8'h02;
        cyc(12);
        chk(fv, 0, "early");
        tnow = ts;
        wait_fv;
        chk({fv, vidx}, 4'b1001, "valid");
        chk(meta, wd(1, 0), "meta");
        chk(ident, wd(1, 1), "ident");
        cmd(0);
        chk({lkd, used, fv}, 3'b110, "lock");
        avail = 8'h22;
        cyc(10);
        chk({lkd, fv, vidx}, 5'b10001, "held");
        cmd(1);
        chk({lkd, done}, 2'b01, "unlock");
        avail = 8'h00;
        cyc(10);
        chk(fv, 0, "none");
    end
    endtask
    // Higher buffer arrives, then is aborted
    task t_prio;
    begin
        avail = 8'h02;
        wait_fv;
        avail = 8'h06;
        cyc(3);
        chk({fv, vidx}, 4'b1001, "old");
        cyc(6);
        chk(vidx, 2, "new");
        chk(ident, wd(2, 1), "swap");
        avail = 8'h02;
        #1;
        chk(fv, 0, "abort");
        wait_fv;
        chk(vidx, 1, "back");
        avail = 8'h00;
        cyc(3);
    end
    endtask
    // Corrupt parity stops validation and names the buffer
    task t_par;
        integer i;
        reg seen;
    begin
        avail = 8'h08;
        bad = 1'b1;
        seen = 1'b0;
        for (i = 0; i < 10; i = i + 1)
        begin
            cyc(1);
            seen = seen | (perr === 1'b1 && pidx === 3'h3);
        end
        chk({seen, fv}, 2'b10, "parity");
        bad = 1'b0;
        avail = 8'h00;
    end
    endtask
    task summarize;
    begin
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    // Main sequence
    initial
    begin
        cyc(12);
        chk({fv, lkd, vidx, used}, 0, "reset");
        rst_n = 1'b1;
        cyc(2);
        t_basic;
        $display("test basic done");
        t_prio;
        $display("test prio done");
        t_par;
        $display("test parity done");
        summarize;
    end
    // Watchdog far beyond the hundred or so cycles needed
    initial
    begin
        #50000;
        error_cnt = error_cnt + 1;
        summarize;
    end
endmodule
